// ==== core/clock_calendar_block_pkg.sv ====
/*
 * Package for the clock-calendar control and date block.
 * Assumes a single 25 MHz bus clock and an AHB-Lite register port.
 */
package clock_calendar_block_pkg;
    localparam logic [7:0]  CTRL_OFFS      = 8'h00;
    localparam logic [7:0]  DATE_OFFS      = 8'h04;
    localparam logic [7:0]  TIME_OFFS      = 8'h08;
    localparam logic [7:0]  UNLK_OFFS      = 8'h0c;
    localparam int          CAL_LSB        = 16;
    localparam int          CAL_W          = 10;
    localparam int          ON_BIT         = 15;
    localparam int          IDLE_STOP_BIT       = 13;
    localparam int          SECSEL_BIT     = 7;
    localparam int          CLKON_BIT      = 6;
    localparam int          WREN_BIT       = 3;
    localparam int          SYNC_BIT       = 2;
    localparam int          HALF_BIT       = 1;
    localparam int          OE_BIT         = 0;
    localparam logic [31:0] CTRL_WMASK     = 32'h03ff_a089;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [31:0] DATE_MASK      = 32'hff1f_3f07;
    localparam logic [31:0] DATE_RESET     = 32'h0000_0000;
    localparam logic [31:0] TIME_SEC_MASK  = 32'h0000_7f00;
    localparam logic [31:0] UNLOCK_KEY     = 32'h0000_00a5;
    // Timebase pulses per minute nominal (arbitrary parameter default)
    localparam int          TB_PER_MIN     = 60;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
    localparam logic [1:0]  HSIZE_WORD     = 2'b10;
endpackage

// ==== core/clock_calendar_block_trim.sv ====
/*
 * Per-minute drift trim of the calendar timebase.
 * Assumes tb_tick is a one-cycle pulse per raw timebase period.
 */
`timescale 1ns/100ps
module clock_calendar_block_trim
#(
    parameter int TB_PER_MIN = 60
)
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       en,
    input  wire logic       tb_tick,
    input  wire logic [9:0] cal,
    output logic            trim_tick,
    output logic            min_pulse
);
    logic [15:0] cnt_q, cnt_d;
    logic [9:0]  add_q, add_d;
    logic [9:0]  del_q, del_d;
    logic        tick_d, min_d;

    always_comb
    begin
        cnt_d  = cnt_q;
        add_d  = add_q;
        del_d  = del_q;
        tick_d = 1'b0;
        min_d  = 1'b0;
        if (!en)
        begin
            cnt_d = '0;
            add_d = '0;
            del_d = '0;
        end
        else if (tb_tick)
        begin
            if (del_q != '0)
                del_d = del_q - 10'd1;
            else
                tick_d = 1'b1;
            if (cnt_q == 16'(TB_PER_MIN - 1))
            begin
                cnt_d = '0;
                min_d = 1'b1;
                if (!cal[9])
                    add_d = cal;
                else
                    del_d = 10'(~cal + 10'd1);
                if (cal == 10'h200)
                    del_d = 10'h200;
            end
            else
                cnt_d = cnt_q + 16'd1;
        end
        else if (add_q != '0)
        begin
            // Extra pulse only in a cycle free of raw ticks, none is lost
            tick_d = 1'b1;
            add_d  = add_q - 10'd1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q     <= '0;
            add_q     <= '0;
            del_q     <= '0;
            trim_tick <= 1'b0;
            min_pulse <= 1'b0;
        end
        else
        begin
            cnt_q     <= cnt_d;
            add_q     <= add_d;
            del_q     <= del_d;
            trim_tick <= tick_d;
            min_pulse <= min_d;
        end
    end
endmodule

// ==== core/clock_calendar_block_core.sv ====
/*
 * Control and date registers of the clock-calendar block, AHB-Lite slave.
 * Assumes hclk at 25 MHz, single word transfers, one slave on the bus.
 */
`timescale 1ns/100ps
// Function
// - Positive trim codes add that many timebase pulses each minute.
// - Negative trim codes remove pulses; most negative removes 512.
// - Control bit 15 enables block clock, trim, pin and running flag; date writes and half flag do not depend on it.
// - Enable bit writes ignored unless write unlock is set.
// - Idle stop bit gates block clock while in idle mode.
// - Pin source bit 7 picks seconds clock or alarm pulse.
// - Pin stays inactive unless pin output enable is one.
// - Status bit 6 shows timebase clock running.
// - Write unlock sets only while write sequence is enabled.
// - Half second flag read-only, cleared by seconds field write.
// - Control register resets only on power-on reset.
// - Year held as two BCD digits in bits 31-24.
// - Month tens at bit 20, units at bits 19-16.
// - Day tens bits 13-12, units bits 11-8.
// - Weekday three bits in 2-0, zero to six.
// - Date writes accepted only while write unlock is one.
// - Unimplemented control and date bits read zero.
module clock_calendar_block_core
    import clock_calendar_block_pkg::*;
#(
    parameter int TB_PER_MIN_P = clock_calendar_block_pkg::TB_PER_MIN
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        por_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        tb_tick,
    input  wire logic        tb_running,
    input  wire logic        idle_mode,
    input  wire logic        write_seq_en,
    input  wire logic        seconds_clk,
    input  wire logic        alarm_pulse,
    input  wire logic        half_sec_in,
    output logic             clock_calendar_block_pin,
    output logic             blk_clk_en,
    output logic             trim_tick,
    output logic             min_pulse
);
    import clock_calendar_block_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic        wr_q, wr_d;
    logic        rd_q, rd_d;
    logic [7:0]  ad_q, ad_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] date_q, date_d;
    logic        half_q, half_d;
    logic        run_q, run_d;
    logic        hin_q, hin_d;
    logic [31:0] rdata_d;
    logic        pin_d;
    logic        gate_d;
    logic        acc;
    logic [31:0] ctrl_rd;

    assign acc = hsel && hready && htrans == HTRANS_NONSEQ;

    ////////////////////////////////////////////////////////////////////////
    // Address phase capture, zero wait state data phase
    always_comb
    begin
        wr_d = acc && hwrite && hsize == {1'b0, HSIZE_WORD};
        rd_d = acc && !hwrite;
        ad_d = acc ? haddr[7:0] : ad_q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            ad_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            ad_q <= ad_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register, power-on reset domain only
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_q && ad_q == CTRL_OFFS)
        begin
            ctrl_d = (ctrl_q & ~CTRL_WMASK) | (hwdata & CTRL_WMASK);
            if (!ctrl_q[WREN_BIT])
                ctrl_d[ON_BIT] = ctrl_q[ON_BIT];
            if (!write_seq_en && !ctrl_q[WREN_BIT])
                ctrl_d[WREN_BIT] = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge por_n)
    begin
        if (!por_n)
            ctrl_q <= CTRL_RESET;
        else
            ctrl_q <= ctrl_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Date register and status flags
    always_comb
    begin
        date_d = date_q;
        if (wr_q && ad_q == DATE_OFFS && ctrl_q[WREN_BIT])
            date_d = hwdata & DATE_MASK;
        // Flag set on a rising half-second phase, held until it falls
        hin_d  = half_sec_in;
        half_d = half_q;
        if (half_sec_in && !hin_q)
            half_d = 1'b1;
        else if (!half_sec_in)
            half_d = 1'b0;
        // A time write clears the flag, and wins over a set
        if (wr_q && ad_q == TIME_OFFS)
            half_d = 1'b0;
        run_d = tb_running && ctrl_q[ON_BIT];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            date_q <= DATE_RESET;
            half_q <= 1'b0;
            run_q  <= 1'b0;
            hin_q  <= 1'b0;
        end
        else
        begin
            date_q <= date_d;
            half_q <= half_d;
            run_q  <= run_d;
            hin_q  <= hin_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux and pin outputs
    always_comb
    begin
        ctrl_rd = ctrl_q & CTRL_WMASK;
        ctrl_rd[CLKON_BIT] = run_q;
        ctrl_rd[HALF_BIT]  = half_q;
        ctrl_rd[SYNC_BIT]  = 1'b0;
        rdata_d = '0;
        if (rd_d)
        begin
            unique case (haddr[7:0])
                CTRL_OFFS: rdata_d = ctrl_rd;
                DATE_OFFS: rdata_d = date_q & DATE_MASK;
                default:   rdata_d = '0;
            endcase
        end
        pin_d = 1'b0;
        if (ctrl_q[OE_BIT] && ctrl_q[ON_BIT])
            pin_d = ctrl_q[SECSEL_BIT] ? seconds_clk : alarm_pulse;
        gate_d = ctrl_q[ON_BIT];
        if (idle_mode && ctrl_q[IDLE_STOP_BIT])
            gate_d = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata     <= '0;
            clock_calendar_block_pin   <= 1'b0;
            blk_clk_en <= 1'b0;
        end
        else
        begin
            hrdata     <= rdata_d;
            clock_calendar_block_pin   <= pin_d;
            blk_clk_en <= gate_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drift trimming runs only while enabled and clock not gated
    clock_calendar_block_trim #(.TB_PER_MIN(TB_PER_MIN_P)) u_trim
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .en        (blk_clk_en),
        .tb_tick   (tb_tick),
        .cal       (ctrl_q[CAL_LSB +: CAL_W]),
        .trim_tick (trim_tick),
        .min_pulse (min_pulse)
    );

    ////////////////////////////////////////////////////////////////////////
    property p_on_locked;
        @(posedge hclk) disable iff (!hresetn || !por_n)
        (wr_q && ad_q == CTRL_OFFS && !ctrl_q[WREN_BIT])
            |=> ctrl_q[ON_BIT] == $past(ctrl_q[ON_BIT]);
    endproperty
    a_on_locked: assert property (p_on_locked)
        else $error("enable changed while locked");

    property p_wren_seq;
        @(posedge hclk) disable iff (!hresetn || !por_n)
        (!ctrl_q[WREN_BIT] && !write_seq_en) |=> !ctrl_q[WREN_BIT];
    endproperty
    a_wren_seq: assert property (p_wren_seq)
        else $error("unlock set without write sequence");

    property p_date_lock;
        @(posedge hclk) disable iff (!hresetn)
        !ctrl_q[WREN_BIT] |=> $stable(date_q);
    endproperty
    a_date_lock: assert property (p_date_lock)
        else $error("date changed while locked");

    property p_date_zero;
        @(posedge hclk) disable iff (!hresetn)
        rd_q && ad_q == DATE_OFFS |-> (hrdata & ~DATE_MASK) == 32'h0;
    endproperty
    a_date_zero: assert property (p_date_zero)
        else $error("date unused bits nonzero");

    property p_ctrl_zero;
        @(posedge hclk) disable iff (!hresetn)
        rd_q && ad_q == CTRL_OFFS |-> hrdata[31:26] == 6'h0;
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero)
        else $error("control upper bits nonzero");

    property p_pin_off;
        @(posedge hclk) disable iff (!hresetn || !por_n)
        !ctrl_q[OE_BIT] |=> !clock_calendar_block_pin;
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("pin active without enable");

    property p_pin_sel;
        @(posedge hclk) disable iff (!hresetn || !por_n)
        ctrl_q[OE_BIT] && ctrl_q[ON_BIT] && ctrl_q[SECSEL_BIT]
            |=> clock_calendar_block_pin == $past(seconds_clk);
    endproperty
    a_pin_sel: assert property (p_pin_sel)
        else $error("pin not following seconds clock");

    property p_idle_gate;
        @(posedge hclk) disable iff (!hresetn || !por_n)
        idle_mode && ctrl_q[IDLE_STOP_BIT] |=> !blk_clk_en;
    endproperty
    a_idle_gate: assert property (p_idle_gate)
        else $error("clock not gated in idle");

    property p_half_clr;
        @(posedge hclk) disable iff (!hresetn)
        wr_q && ad_q == TIME_OFFS |=> !half_q;
    endproperty
    a_half_clr: assert property (p_half_clr)
        else $error("half second flag not cleared");

    property p_clkon;
        @(posedge hclk) disable iff (!hresetn || !por_n)
        !ctrl_q[ON_BIT] |=> !run_q ##1 !ctrl_rd[CLKON_BIT] || ctrl_q[ON_BIT];
    endproperty
    a_clkon: assert property (p_clkon)
        else $error("clock running flag while off");

    property p_run_on;
        @(posedge hclk) disable iff (!hresetn || !por_n)
        tb_running && ctrl_q[ON_BIT] |=> run_q;
    endproperty
    a_run_on: assert property (p_run_on)
        else $error("clock running flag missing");

    property p_half_set;
        @(posedge hclk) disable iff (!hresetn)
        half_sec_in && !hin_q && !(wr_q && ad_q == TIME_OFFS) |=> half_q;
    endproperty
    a_half_set: assert property (p_half_set)
        else $error("half second flag not set");

    property p_on_open;
        @(posedge hclk) disable iff (!hresetn || !por_n)
        (wr_q && ad_q == CTRL_OFFS && ctrl_q[WREN_BIT])
            |=> ctrl_q[ON_BIT] == $past(hwdata[ON_BIT]);
    endproperty
    a_on_open: assert property (p_on_open)
        else $error("enable write lost while unlocked");

    property p_date_wr;
        @(posedge hclk) disable iff (!hresetn || !por_n)
        (wr_q && ad_q == DATE_OFFS && ctrl_q[WREN_BIT])
            |=> date_q == ($past(hwdata) & DATE_MASK);
    endproperty
    a_date_wr: assert property (p_date_wr)
        else $error("date write lost while unlocked");

    property p_blk_off;
        @(posedge hclk) disable iff (!hresetn || !por_n)
        !ctrl_q[ON_BIT] |=> !blk_clk_en;
    endproperty
    a_blk_off: assert property (p_blk_off)
        else $error("block clock enabled while off");

    property p_trim_off;
        @(posedge hclk) disable iff (!hresetn)
        !blk_clk_en |=> !trim_tick;
    endproperty
    a_trim_off: assert property (p_trim_off)
        else $error("trim tick while block stopped");

    property p_pin_alm;
        @(posedge hclk) disable iff (!hresetn || !por_n)
        ctrl_q[OE_BIT] && ctrl_q[ON_BIT] && !ctrl_q[SECSEL_BIT]
            |=> clock_calendar_block_pin == $past(alarm_pulse);
    endproperty
    a_pin_alm: assert property (p_pin_alm)
        else $error("pin not following alarm pulse");
endmodule

// ==== dv/rtc_control_and_date_tb.sv ====
/*
 * Self-checking bench for the clock-calendar control and date block.
 * Assumes the zero-wait AHB-Lite slave of clock_calendar_block_core, driven here directly.
 */
`timescale 1ns/100ps
module rtc_control_and_date_tb;
    import clock_calendar_block_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        por_n = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = '0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        tb_tick = 1'b0;
    logic        tb_running = 1'b1;
    logic        idle_mode = 1'b0;
    logic        write_seq_en = 1'b0;
    logic        seconds_clk = 1'b0;
    logic        alarm_pulse = 1'b0;
    logic        half_sec_in = 1'b0;
    logic        clock_calendar_block_pin;
    logic        blk_clk_en;
    logic        trim_tick;
    logic        min_pulse;
    logic [1:0]  tcnt = '0;
    logic [31:0] d;
    int          err_total = 0;
    int          samples_checked = 0;
    localparam logic [31:0] UNL = 32'h0000_0008;
    localparam logic [31:0] ONB = 32'h0000_8000;

    clock_calendar_block_core #(.TB_PER_MIN_P(4)) dut (
        .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize({1'b0, HSIZE_WORD}), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .tb_tick(tb_tick), .tb_running(tb_running), .idle_mode(idle_mode),
        .write_seq_en(write_seq_en), .seconds_clk(seconds_clk),
        .alarm_pulse(alarm_pulse), .half_sec_in(half_sec_in),
        .clock_calendar_block_pin(clock_calendar_block_pin), .blk_clk_en(blk_clk_en),
        .trim_tick(trim_tick), .min_pulse(min_pulse));

    always #20 hclk = ~hclk;

    // Raw timebase: one tick every fourth bus clock
    always @(posedge hclk)
    begin
        tcnt <= tcnt + 2'd1;
        tb_tick <= (tcnt == 2'd3);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] rd);
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        xfer(a, 1'b1, v, x);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
        xfer(a, 1'b0, '0, d);
        check(nm, d, e);
    endtask

    task automatic pin_chk(input logic e);
        repeat (3) @(posedge hclk);
        #1;
        check("pin", {31'h0, clock_calendar_block_pin}, {31'h0, e});
    endtask

    // Trim ticks counted across one minute once the trim has settled
    task automatic trim_chk(input logic [9:0] c, input int e);
        int n;
        wr(CTRL_OFFS, {6'h0, c, ONB[15:0] | UNL[15:0]});
        n = 0;
        repeat (3)
        begin
            n = 0;
            do
            begin
                @(posedge hclk);
                n += int'(trim_tick);
            end
            while (min_pulse !== 1'b1);
        end
        check("trim", n, e);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #2_000_000;
        err_total++;
        test_done();
    end

    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        por_n <= 1'b1;
        repeat (2) @(posedge hclk);
        rchk("ctrl", CTRL_OFFS, CTRL_RESET);
        rchk("date", DATE_OFFS, DATE_RESET);
        rchk("unmapped", UNLK_OFFS, 32'h0);
        check("hresp", {31'h0, hresp}, 32'h0);
        wr(CTRL_OFFS, UNL);
        rchk("ctrl", CTRL_OFFS, 32'h0);
        wr(DATE_OFFS, 32'h0000_0012);
        rchk("date", DATE_OFFS, 32'h0);
        write_seq_en <= 1'b1;
        wr(CTRL_OFFS, UNL | ONB);
        rchk("ctrl", CTRL_OFFS, UNL);
        write_seq_en <= 1'b0;
        wr(CTRL_OFFS, 32'hffff_ffff);
        @(posedge hclk);
        rchk("ctrl", CTRL_OFFS, CTRL_WMASK | 32'h40);
        wr(DATE_OFFS, 32'hffff_ffff);
        rchk("date", DATE_OFFS, DATE_MASK);
        wr(DATE_OFFS, 32'h9912_3106);
        rchk("date", DATE_OFFS, 32'h9912_3106);
        check("blk", {31'h0, blk_clk_en}, 32'h1);
        idle_mode <= 1'b1;
        repeat (3) @(posedge hclk);
        check("blk", {31'h0, blk_clk_en}, 32'h0);
        idle_mode <= 1'b0;
        seconds_clk <= 1'b1;
        pin_chk(1'b1);
        seconds_clk <= 1'b0;
        alarm_pulse <= 1'b1;
        pin_chk(1'b0);
        wr(CTRL_OFFS, 32'hffff_ff7f);
        pin_chk(1'b1);
        wr(CTRL_OFFS, 32'hffff_ff7e);
        pin_chk(1'b0);
        tb_running <= 1'b0;
        repeat (3) @(posedge hclk);
        rchk("ctrl", CTRL_OFFS, CTRL_WMASK & 32'hffff_ff7e);
        tb_running <= 1'b1;
        half_sec_in <= 1'b1;
        repeat (3) @(posedge hclk);
        xfer(CTRL_OFFS, 1'b0, '0, d);
        check("half", {31'h0, d[HALF_BIT]}, 32'h1);
        wr(TIME_OFFS, 32'h0000_0100);
        xfer(CTRL_OFFS, 1'b0, '0, d);
        check("half", {31'h0, d[HALF_BIT]}, 32'h0);
        half_sec_in <= 1'b0;
        trim_chk(10'h000, 4);
        trim_chk(10'h003, 7);
        trim_chk(10'h3ff, 3);
        trim_chk(10'h3fe, 2);
        wr(DATE_OFFS, 32'h2501_1503);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rchk("ctrl", CTRL_OFFS, 32'h03fe_8008 | 32'h40);
        rchk("date", DATE_OFFS, DATE_RESET);
        wr(CTRL_OFFS, UNL);
        repeat (2) @(posedge hclk);
        check("blk", {31'h0, blk_clk_en}, 32'h0);
        rchk("ctrl", CTRL_OFFS, UNL);
        test_done();
    end
endmodule
